// File: ftl_pkg.sv
// Package with constants, register map and carrier types for the fine grain lookup block.
package ftl_pkg;

   // Sizes of the translation array and of the address paths.
   localparam int TLB_ENTRIES = 16;
   localparam int IDX_W       = 4;
   localparam int VA_W        = 32;
   localparam int PA_W        = 32;
   localparam int PFN_W       = 20;
   localparam int MASK_W      = 14;
   localparam int VPN_W       = 21;
   localparam int ADDRESS_SPACE_ID_W      = 8;
   localparam int GRAIN_W     = 2;
   localparam int ADDR_W      = 12;
   localparam int HALF_POS_MIN = 10;

   // Register byte addresses: four times (coprocessor register * 8 + select).
   localparam logic [ADDR_W-1:0] ADDR_INDEX   = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_EVEN_LO = 12'h040;
   localparam logic [ADDR_W-1:0] ADDR_ODD_LO  = 12'h060;
   localparam logic [ADDR_W-1:0] ADDR_PMASK   = 12'h0a0;
   localparam logic [ADDR_W-1:0] ADDR_GRAIN   = 12'h0a4;
   localparam logic [ADDR_W-1:0] ADDR_TAG     = 12'h140;
   localparam logic [ADDR_W-1:0] ADDR_FEAT    = 12'h208;
   localparam logic [ADDR_W-1:0] ADDR_CMD     = 12'h300;

   // Field positions inside the registers.
   localparam int LO_RI_BIT    = 31;
   localparam int LO_XI_BIT    = 30;
   localparam int LO_PFN_LSB   = 6;
   localparam int LO_C_LSB     = 3;
   localparam int LO_D_BIT     = 2;
   localparam int LO_V_BIT     = 1;
   localparam int LO_G_BIT     = 0;
   localparam int PMASK_LSB    = 11;
   localparam int TAG_VPN_LSB  = 11;
   localparam int FEAT_EXT_BIT   = 1;
   localparam int FEAT_SMALL_BIT = 4;
   localparam int CMD_WRITE_BIT  = 0;

   // Granularity mask encodings; each set bit pins one more low page bit, so 11 gives 4 KB.
   localparam logic [GRAIN_W-1:0] GRAIN_1K = 2'h0;
   localparam logic [GRAIN_W-1:0] GRAIN_2K = 2'h1;
   localparam logic [GRAIN_W-1:0] GRAIN_4K = 2'h3;

   // Reset values.
   localparam logic [MASK_W-1:0]  PMASK_RESET = 14'h0000;
   localparam logic [GRAIN_W-1:0] GRAIN_RESET = 2'h0;

   typedef enum logic [1:0] {
      REF_FETCH,
      REF_LOAD,
      REF_STORE
   } ftl_ref_type;

   typedef struct packed {
      logic [PFN_W-1:0] frame;
      logic             valid;
      logic [2:0]       cache;
      logic             dirty;
      logic             readInhibit;
      logic             execInhibit;
   } ftl_half_type;

   typedef struct packed {
      logic [VPN_W-1:0]  vpnTag;
      logic [MASK_W-1:0] mask;
      logic              global;
      logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
      ftl_half_type      even;
      ftl_half_type      odd;
   } ftl_entry_type;

   typedef struct packed {
      logic            valid;
      logic [VA_W-1:0] va;
      ftl_ref_type     refType;
      logic            pcRelative;
   } ftl_req_type;

   typedef struct packed {
      logic            valid;
      logic [PA_W-1:0] pa;
      logic [2:0]      cache;
      logic            miss;
      logic            invalid;
      logic            writeProtect;
      ftl_ref_type     refType;
   } ftl_result_type;

endpackage

// File: ftl_lookup.sv
// Joint-entry translation lookup with 1 KB, 2 KB and 4 KB granularity and an APB register port.
`timescale 1ns/1ps

// Functional notes
// - Entry matches on tag bits 31..11 outside mask, and global or same space id.
// - Search entries from index zero upward; first match wins.
// - Effective mask is entry mask ORed with zero-extended granularity mask.
// - Effective mask decodes to half-select position 10,11,12 or even 14..24.
// - Half-select address bit zero picks even half, otherwise odd half.
// - Selected half not valid raises invalid-translation fault with reference type.
// - Load on read-inhibited half faults unless execute allowed and load is PC relative.
// - Fetch on execute-inhibited half raises invalid-translation fault.
// - Store on half with dirty clear raises write-protect fault.
// - No matching entry raises translation-miss fault with reference type.
// - Frame number aligned by granularity: 00 pad high, 01 split, 11 pad low.
// - Physical address is aligned frame above half position plus in-page offset.
// - Granularity register selects 4 KB, 2 KB or 1 KB minimum pages.
// - Page sizes above 16 MB are not supported, leaving small pages intact.
// - Small-page legacy flag in feature word reads zero.
// - Extension-present flag in feature word reads one at register 16 select 2.
// - Page mask 5/0, granularity 5/1, tag holder 10/0 by coprocessor select.
// - Granularity-inhibited mask bits 12,11 match as ones, read zero, ignore writes.
// - On any fault, tag holder captures address bits 31..13 and bits 12,11 outside granularity mask; its space id keeps its value.
module ftl_lookup (
   // Clock and reset
   input  wire  logic                    clock,
   input  wire  logic                    srst,
   // APB register port
   input  wire  logic                    psel,
   input  wire  logic                    penable,
   input  wire  logic                    pwrite,
   input  wire  logic [ftl_pkg::ADDR_W-1:0] paddr,
   input  wire  logic [31:0]             pwdata,
   output logic                          pready,
   output logic [31:0]                   prdata,
   output logic                          pslverr,
   // Lookup request from the pipeline and its answer
   input  wire  ftl_pkg::ftl_req_type    lookupReq,
   output ftl_pkg::ftl_result_type       lookupResult
);
   import ftl_pkg::*;

   typedef struct packed {
      ftl_entry_type [TLB_ENTRIES-1:0] entries;
      logic [MASK_W-1:0]               pageMask;
      logic [GRAIN_W-1:0]              grain;
      logic [VPN_W-1:0]                tagVpn;
      logic [ADDRESS_SPACE_ID_W-1:0]               tagAsid;
      logic [31:0]                     evenLo;
      logic [31:0]                     oddLo;
      logic [IDX_W-1:0]                index;
      ftl_result_type                  result;
      logic                            pready;
      logic [31:0]                     prdata;
      logic                            pslverr;
   } ftl_state_type;

   ftl_state_type state;
   ftl_state_type next_state;

   logic                found;
   logic [TLB_ENTRIES-1:0] matchVec;
   logic [IDX_W-1:0]    hitIdx;
   logic [MASK_W-1:0]   effMask;
   logic [4:0]          halfPos;
   ftl_half_type        half;
   logic [PA_W-1:10]    pfnAligned;
   logic [PA_W-1:0]     lowMask;
   logic                faultInvalid;
   logic                faultWrite;
   logic                anyFault;
   logic [31:0]         readData;
   logic                mapped;
   logic                apbSetup;
   logic                apbWrite;
   logic [MASK_W-1:0]   grainExt;

   // Half-select position from the effective mask; anything else is undefined, take 10.
   function automatic logic [4:0] ftl_half_pos(input logic [MASK_W-1:0] m);
      case (m)
         14'h0000: ftl_half_pos = 5'h0a;
         14'h0001: ftl_half_pos = 5'h0b;
         14'h0003: ftl_half_pos = 5'h0c;
         14'h000f: ftl_half_pos = 5'h0e;
         14'h003f: ftl_half_pos = 5'h10;
         14'h00ff: ftl_half_pos = 5'h12;
         14'h03ff: ftl_half_pos = 5'h14;
         14'h0fff: ftl_half_pos = 5'h16;
         14'h3fff: ftl_half_pos = 5'h18;
         default:  ftl_half_pos = 5'h0a;
      endcase
   endfunction

   function automatic ftl_half_type ftl_unpack_half(input logic [31:0] lo);
      ftl_half_type h;
      h.frame       = lo[LO_PFN_LSB +: PFN_W];
      h.valid       = lo[LO_V_BIT];
      h.cache       = lo[LO_C_LSB +: 3];
      h.dirty       = lo[LO_D_BIT];
      h.readInhibit = lo[LO_RI_BIT];
      h.execInhibit = lo[LO_XI_BIT];
      return h;
   endfunction

   always_comb begin
      next_state   = state;
      found        = 1'b0;
      hitIdx       = '0;
      matchVec     = '0;
      grainExt     = {12'h000, state.grain};
      effMask      = '0;
      halfPos      = 5'h0a;
      half         = '0;
      pfnAligned   = '0;
      lowMask      = '0;
      faultInvalid = 1'b0;
      faultWrite   = 1'b0;
      anyFault     = 1'b0;
      readData     = 32'h0000_0000;
      mapped       = 1'b1;
      apbSetup     = psel & ~penable;
      apbWrite     = psel & penable & state.pready & pwrite;

      // Priority search; inhibited mask bits take part as ones in the compare.
      for (int i = 0; i < TLB_ENTRIES; i++) begin
         matchVec[i] = ((state.entries[i].vpnTag & ~{7'h00, state.entries[i].mask | grainExt})
                        == (lookupReq.va[31:11] & ~{7'h00, state.entries[i].mask | grainExt}))
                       && (state.entries[i].global
                           || state.entries[i].address_space_id == state.tagAsid);
         if (!found && matchVec[i]) begin
            found  = 1'b1;
            hitIdx = IDX_W'(i);
         end
      end

      effMask = state.entries[hitIdx].mask | grainExt;
      halfPos = ftl_half_pos(effMask);
      half    = lookupReq.va[halfPos] ? state.entries[hitIdx].odd
                                      : state.entries[hitIdx].even;

      // Align the frame to physical bit 10; 10 is reserved and aligns like 1 KB.
      case (state.grain)
         GRAIN_2K: pfnAligned = {1'b0, half.frame, 1'b0};
         GRAIN_4K: pfnAligned = {half.frame, 2'h0};
         default:  pfnAligned = {2'h0, half.frame};
      endcase
      lowMask = (32'h0000_0001 << halfPos) - 32'h0000_0001;

      faultInvalid = !half.valid
         || (lookupReq.refType == REF_LOAD && half.readInhibit
             && !(!half.execInhibit && lookupReq.pcRelative))
         || (lookupReq.refType == REF_FETCH && half.execInhibit);
      faultWrite = half.valid && lookupReq.refType == REF_STORE && !half.dirty;

      next_state.result.valid        = lookupReq.valid;
      next_state.result.refType      = lookupReq.refType;
      next_state.result.miss         = lookupReq.valid && !found;
      next_state.result.invalid      = lookupReq.valid && found && faultInvalid;
      next_state.result.writeProtect = lookupReq.valid && found && !faultInvalid
                                       && faultWrite;
      next_state.result.cache        = found ? half.cache : 3'h0;
      next_state.result.pa           = found ? (({pfnAligned, 10'h000} & ~lowMask)
                                                | (lookupReq.va & lowMask)) : '0;
      anyFault = lookupReq.valid && (!found || faultInvalid || faultWrite);

      // APB: read data is latched in the setup cycle, pready follows one cycle later.
      if (paddr == ADDR_INDEX) begin
         readData = {28'h0000000, state.index};
      end else if (paddr == ADDR_EVEN_LO) begin
         readData = state.evenLo;
      end else if (paddr == ADDR_ODD_LO) begin
         readData = state.oddLo;
      end else if (paddr == ADDR_PMASK) begin
         readData = {7'h00, state.pageMask & ~grainExt, 11'h000};
      end else if (paddr == ADDR_GRAIN) begin
         readData = {30'h0, state.grain};
      end else if (paddr == ADDR_TAG) begin
         readData = {state.tagVpn, 3'h0, state.tagAsid};
      end else if (paddr == ADDR_FEAT) begin
         readData = 32'h0000_0000;
         readData[FEAT_EXT_BIT] = 1'b1;
      end else if (paddr == ADDR_CMD) begin
         readData = 32'h0000_0000;
      end else begin
         mapped = 1'b0;
      end

      next_state.pready = apbSetup;
      if (apbSetup) begin
         next_state.prdata  = pwrite ? 32'h0000_0000 : readData;
         next_state.pslverr = !mapped;
      end

      if (apbWrite) begin
         if (paddr == ADDR_INDEX) begin
            next_state.index = pwdata[IDX_W-1:0];
         end else if (paddr == ADDR_EVEN_LO) begin
            next_state.evenLo = pwdata;
         end else if (paddr == ADDR_ODD_LO) begin
            next_state.oddLo = pwdata;
         end else if (paddr == ADDR_PMASK) begin
            next_state.pageMask = (pwdata[PMASK_LSB +: MASK_W] & ~grainExt)
                                  | (state.pageMask & grainExt);
         end else if (paddr == ADDR_GRAIN) begin
            next_state.grain = pwdata[GRAIN_W-1:0];
         end else if (paddr == ADDR_TAG) begin
            next_state.tagVpn  = pwdata[TAG_VPN_LSB +: VPN_W];
            next_state.tagAsid = pwdata[ADDRESS_SPACE_ID_W-1:0];
         end else if (paddr == ADDR_CMD && pwdata[CMD_WRITE_BIT]) begin
            next_state.entries[state.index].vpnTag = state.tagVpn;
            next_state.entries[state.index].mask   = state.pageMask;
            next_state.entries[state.index].address_space_id   = state.tagAsid;
            next_state.entries[state.index].global = state.evenLo[LO_G_BIT]
                                                     & state.oddLo[LO_G_BIT];
            next_state.entries[state.index].even   = ftl_unpack_half(state.evenLo);
            next_state.entries[state.index].odd    = ftl_unpack_half(state.oddLo);
         end
      end

      // A fault capture wins over a software write of the tag address bits in the same cycle; a space id write still lands.
      if (anyFault) begin
         next_state.tagVpn = {lookupReq.va[31:13], lookupReq.va[12:11] & ~state.grain};
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state          <= '0;
         state.pageMask <= PMASK_RESET;
         state.grain    <= GRAIN_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign pready       = state.pready;
   assign prdata       = state.prdata;
   assign pslverr      = state.pslverr;
   assign lookupResult = state.result;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_miss_raised: assert property (
      lookupReq.valid && !found |=> lookupResult.miss && lookupResult.valid
                                    && !lookupResult.invalid)
      else $error("Miss not flagged one cycle after unmatched lookup.");

   a_offset_kept: assert property (
      lookupReq.valid && found |=> lookupResult.pa[9:0] == $past(lookupReq.va[9:0]))
      else $error("In-page offset bits not carried to physical address.");

   a_store_protect: assert property (
      lookupReq.valid && found && half.valid && !half.dirty
      && lookupReq.refType == REF_STORE && !half.readInhibit
      |=> lookupResult.writeProtect)
      else $error("Store to clean page did not raise write-protect.");

   a_fetch_inhibit: assert property (
      lookupReq.valid && found && half.execInhibit && lookupReq.refType == REF_FETCH
      |=> lookupResult.invalid && lookupResult.refType == REF_FETCH)
      else $error("Fetch from execute-inhibited page not refused.");

   a_tag_capture: assert property (
      anyFault |=> state.tagVpn[VPN_W-1:2] == $past(lookupReq.va[31:13]))
      else $error("Tag holder did not capture failing address.");

   // The chosen entry must match and every entry below it must miss, so an overlap
   // of two entries always resolves to the lower index.
   a_first_match: assert property (
      found |-> matchVec[hitIdx]
                && (matchVec & ((TLB_ENTRIES'(1) << hitIdx) - TLB_ENTRIES'(1))) == '0)
      else $error("Lower index matching entry was passed over.");

   a_feature_flags: assert property (
      apbSetup && !pwrite && paddr == ADDR_FEAT
      |=> prdata[FEAT_SMALL_BIT] == 1'b0 && prdata[FEAT_EXT_BIT] == 1'b1 && pready)
      else $error("Feature word flags read wrong.");

   a_mask_inhibit: assert property (
      apbSetup && !pwrite && paddr == ADDR_PMASK && state.grain == GRAIN_4K
      |=> prdata[12:11] == 2'h0)
      else $error("Inhibited page mask bits did not read as zero.");

   a_pc_load: assert property (
      lookupReq.valid && found && half.valid && half.readInhibit && !half.execInhibit
      && lookupReq.pcRelative && lookupReq.refType == REF_LOAD
      |=> !lookupResult.invalid)
      else $error("PC-relative load on executable page was refused.");

   a_apb_answer: assert property (
      apbSetup |=> pready ##1 !pready)
      else $error("APB answer not exactly one access cycle.");

   // Frame checks use the smallest half position of each granularity, so the whole
   // aligned frame shows in the physical address above the offset.
   a_frame_small: assert property (
      lookupReq.valid && found && state.grain == GRAIN_1K && halfPos == 5'h0a
      |=> lookupResult.pa[31:10] == {2'h0, $past(half.frame)})
      else $error("Frame not aligned for 1 KB granularity.");

   a_frame_mid: assert property (
      lookupReq.valid && found && state.grain == GRAIN_2K && halfPos == 5'h0b
      |=> lookupResult.pa[31:11] == {1'b0, $past(half.frame)})
      else $error("Frame not aligned for 2 KB granularity.");

   a_frame_large: assert property (
      lookupReq.valid && found && state.grain == GRAIN_4K && halfPos == 5'h0c
      |=> lookupResult.pa[31:12] == $past(half.frame))
      else $error("Frame not aligned for 4 KB granularity.");

   a_invalid_raised: assert property (
      lookupReq.valid && found && !half.valid
      |=> lookupResult.invalid && !lookupResult.writeProtect
          && lookupResult.refType == $past(lookupReq.refType))
      else $error("Invalid half did not raise invalid-translation fault.");

   a_load_inhibit: assert property (
      lookupReq.valid && found && half.valid && half.readInhibit
      && lookupReq.refType == REF_LOAD && (half.execInhibit || !lookupReq.pcRelative)
      |=> lookupResult.invalid)
      else $error("Load from read-inhibited page not refused.");

   a_result_idle: assert property (
      !lookupReq.valid
      |=> !lookupResult.valid && !lookupResult.miss && !lookupResult.invalid
          && !lookupResult.writeProtect)
      else $error("Lookup answer raised without a request.");

   a_mask_keep: assert property (
      apbWrite && paddr == ADDR_PMASK
      |=> (state.pageMask & $past(grainExt)) == ($past(state.pageMask) & $past(grainExt)))
      else $error("Inhibited page mask bits took a write.");

   a_grain_write: assert property (
      apbWrite && paddr == ADDR_GRAIN
      |=> state.grain == $past(pwdata[GRAIN_W-1:0]))
      else $error("Granularity write did not land.");

endmodule

// File: ftl_core_model.sv
// Pipeline-side model that issues lookups and collects the one-cycle answer.
`timescale 1ns/1ps
module ftl_core_model (
   // Clock
   input  wire logic                     clock,
   // Request out and answer back
   output ftl_pkg::ftl_req_type          lookupReq,
   input  wire ftl_pkg::ftl_result_type  lookupResult
);
   import ftl_pkg::*;

   initial lookupReq = '0;

   // Entered just after a rising edge and left just after one, so requests never overlap.
   task automatic lookup(input logic [31:0] va, input ftl_ref_type rt, input logic pcr,
                         output ftl_result_type res);
      lookupReq <= '{1'b1, va, rt, pcr};
      @(posedge clock);
      // A released request shows inverted address and PC-relative fields, so a stale request cannot pass unseen.
      lookupReq <= '{1'b0, ~va, rt, ~pcr};
      @(negedge clock);
      res = lookupResult;
      @(posedge clock);
   endtask
endmodule

// File: tb.sv
// Self-checking bench for the fine grain lookup block: register port and lookups.
`timescale 1ns/1ps
module tb;
   import ftl_pkg::*;

   logic              clock;
   logic              srst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic              pready;
   logic              pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   ftl_req_type       lookupReq;
   ftl_result_type    lookupResult;
   int                n_mismatch = 0;
   int                checks_done = 0;
   logic [1:0]        curG;
   int                curPos;
   localparam logic [2:0] fltNone = 3'h0;
   localparam logic [2:0] fltMiss = 3'h4;
   localparam logic [2:0] fltInv  = 3'h2;
   localparam logic [2:0] fltWp   = 3'h1;
   logic [1:0]        gTab [8] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h1, 2'h0, 2'h3, 2'h0};
   int                pTab [8] = '{10, 11, 12, 12, 12, 14, 14, 24};
   logic [31:0]       mTab [8] = '{32'h0, 32'h0, 32'h0, 32'h1800, 32'h1000, 32'h7800,
                                   32'h7800, 32'h01fff800};

   ftl_lookup dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .lookupReq(lookupReq), .lookupResult(lookupResult));
   ftl_core_model core (.clock(clock), .lookupReq(lookupReq), .lookupResult(lookupResult));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task final_report;
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One transfer; entered just after a rising edge. The answer is taken at the edge
   // where pready is high.
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      logic rdy;
      int   n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         rdy = pready;
         rd = prdata;
         err = pslverr;
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1) check("pready", rdy, 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        e;
      apb(1'b1, a, d, rd, e);
      check("write error", e, 1'b0);
   endtask

   task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic ee);
      logic [31:0] rd;
      logic        e;
      apb(1'b0, a, 32'h0, rd, e);
      check("read data", rd, exp);
      check("read error", e, ee);
   endtask

   function automatic logic [31:0] lo(int ri, int xi, logic [19:0] pfn, logic [2:0] c,
                                      int d, int v, int g);
      return {ri[0], xi[0], 4'h0, pfn, c, d[0], v[0], g[0]};
   endfunction

   task automatic setEntry(input logic [31:0] idx, input logic [31:0] tag,
                           input logic [31:0] mask, input logic [31:0] l0, input logic [31:0] l1);
      wr(ADDR_INDEX, idx);
      wr(ADDR_TAG, tag);
      wr(ADDR_PMASK, mask);
      wr(ADDR_EVEN_LO, l0);
      wr(ADDR_ODD_LO, l1);
      wr(ADDR_CMD, 32'h1);
   endtask

   // Expected address uses the granularity and half position currently set up.
   task automatic lk(input logic [31:0] va, input ftl_ref_type rt, input logic pcr,
                     input logic [2:0] flt, input logic [19:0] pfn, input logic [2:0] c);
      ftl_result_type r;
      logic [31:0]    m;
      logic [21:0]    pp;
      logic [31:0]    pe;
      core.lookup(va, rt, pcr, r);
      m = (32'h1 << curPos) - 32'h1;
      pp = (curG == 2'h0) ? {2'h0, pfn} : (curG == 2'h1) ? {1'b0, pfn, 1'b0} : {pfn, 2'h0};
      pe = (flt == fltMiss) ? 32'h0 : (({pp, 10'h0} & ~m) | (va & m));
      check("result valid", r.valid, 1'b1);
      check("fault flags", {r.miss, r.invalid, r.writeProtect}, flt);
      check("address", r.pa, pe);
      check("cache", r.cache, (flt == fltMiss) ? 3'h0 : c);
      check("reference type", r.refType, rt);
   endtask

   initial begin
      repeat (5000) @(posedge clock);
      check("timeout", 1'b1, 1'b0);
      final_report();
   end

   initial begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      rdChk(ADDR_FEAT, 32'h2, 1'b0);
      rdChk(ADDR_PMASK, 32'h0, 1'b0);
      rdChk(ADDR_GRAIN, 32'h0, 1'b0);
      rdChk(12'h010, 32'h0, 1'b1);
      wr(ADDR_PMASK, 32'hffffffff);
      rdChk(ADDR_PMASK, 32'h01fff800, 1'b0);
      wr(ADDR_GRAIN, 32'h3);
      rdChk(ADDR_PMASK, 32'h01ffe000, 1'b0);
      rdChk(ADDR_GRAIN, 32'h3, 1'b0);
      wr(ADDR_PMASK, 32'h0);
      curG = 2'h3;
      curPos = 12;
      setEntry(32'h1, 32'h12344005, 32'h0, lo(0, 0, 20'habcde, 3'h3, 1, 1, 0),
               lo(0, 0, 20'h54321, 3'h5, 0, 1, 0));
      setEntry(32'h3, 32'h12344005, 32'h0, lo(0, 0, 20'h11111, 3'h3, 1, 1, 0),
               lo(0, 0, 20'h11111, 3'h5, 1, 1, 0));
      setEntry(32'h2, 32'h60000005, 32'h0, lo(1, 0, 20'h44444, 3'h3, 1, 1, 0),
               lo(1, 1, 20'h55555, 3'h5, 1, 1, 0));
      setEntry(32'h7, 32'h70000005, 32'h0, lo(0, 0, 20'h77777, 3'h3, 1, 0, 0),
               lo(0, 1, 20'h66666, 3'h5, 1, 1, 0));
      setEntry(32'h4, 32'h40000009, 32'h0, lo(0, 0, 20'h22222, 3'h3, 1, 1, 0),
               lo(0, 0, 20'h22222, 3'h5, 1, 1, 0));
      setEntry(32'h6, 32'h50000009, 32'h0, lo(0, 0, 20'h33333, 3'h3, 1, 1, 1),
               lo(0, 0, 20'h33333, 3'h5, 1, 1, 1));
      wr(ADDR_TAG, 32'h5);
      lk(32'h12344abc, REF_LOAD, 1'b0, fltNone, 20'habcde, 3'h3);
      lk(32'h12345abc, REF_STORE, 1'b0, fltWp, 20'h54321, 3'h5);
      lk(32'h12344abc, REF_STORE, 1'b0, fltNone, 20'habcde, 3'h3);
      lk(32'h40000010, REF_LOAD, 1'b0, fltMiss, 20'h0, 3'h0);
      lk(32'h50001000, REF_FETCH, 1'b0, fltNone, 20'h33333, 3'h5);
      lk(32'h60000100, REF_LOAD, 1'b0, fltInv, 20'h44444, 3'h3);
      lk(32'h60000100, REF_LOAD, 1'b1, fltNone, 20'h44444, 3'h3);
      lk(32'h60001100, REF_LOAD, 1'b1, fltInv, 20'h55555, 3'h5);
      lk(32'h60001100, REF_FETCH, 1'b0, fltInv, 20'h55555, 3'h5);
      lk(32'h70000200, REF_FETCH, 1'b0, fltInv, 20'h77777, 3'h3);
      lk(32'h70001200, REF_FETCH, 1'b0, fltInv, 20'h66666, 3'h5);
      lk(32'h70001200, REF_LOAD, 1'b0, fltNone, 20'h66666, 3'h5);
      lk(32'h7fff1800, REF_FETCH, 1'b0, fltMiss, 20'h0, 3'h0);
      rdChk(ADDR_TAG, 32'h7fff0005, 1'b0);
      for (int i = 0; i < 8; i++) begin
         curG = gTab[i];
         curPos = pTab[i];
         wr(ADDR_GRAIN, {30'h0, curG});
         setEntry(32'h8, 32'h80000005, mTab[i], lo(0, 0, 20'h9abcd, 3'h3, 1, 1, 0),
                  lo(0, 0, 20'h13579, 3'h5, 0, 1, 0));
         lk(32'h800002a5, REF_STORE, 1'b0, fltNone, 20'h9abcd, 3'h3);
         lk(32'h800002a5 | (32'h1 << curPos), REF_STORE, 1'b0, fltWp, 20'h13579, 3'h5);
      end
      lk(32'h7fff1800, REF_LOAD, 1'b0, fltMiss, 20'h0, 3'h0);
      rdChk(ADDR_TAG, 32'h7fff1805, 1'b0);
      final_report();
   end
endmodule
